// File: rtl/rtcs_pkg.sv
// Package with register map, field positions and timing constants of the clock set block.
package rtcs_pkg;
    localparam int unsigned CLK_HZ            = 20_000_000;
    localparam int unsigned REC_DELAY_MS      = 40;
    localparam int unsigned REC_DELAY_CYC     = (CLK_HZ / 1000) * REC_DELAY_MS;
    localparam int unsigned OSC_HZ            = 32768;
    localparam int unsigned OSC_STEP_CYC      = CLK_HZ / OSC_HZ;
    localparam int unsigned OSC_START_MS      = 10;
    localparam int unsigned OSC_START_CYC     = (CLK_HZ / 1000) * OSC_START_MS;
    localparam logic [14:0] ADDR_CONTROL      = 15'h7FF8;
    localparam logic [14:0] ADDR_SECONDS      = 15'h7FF9;
    localparam logic [14:0] ADDR_DAY          = 15'h7FFC;
    localparam logic [14:0] ADDR_YEAR         = 15'h7FFF;
    localparam int unsigned SET_TIME_POS      = 7;
    localparam int unsigned READ_FREEZE_POS   = 6;
    localparam int unsigned OSC_HALT_POS      = 7;
    localparam int unsigned FREQ_TEST_POS     = 6;
    localparam logic [7:0]  SECONDS_RESET     = 8'h80;
    localparam logic [7:0]  BYTE_ZERO         = 8'h00;
    localparam logic [7:0]  BCD_TEN_SEC_MAX   = 8'h59;

    typedef struct packed {
        logic        chip_sel_n;
        logic        write_n;
        logic        out_en_n;
        logic [14:0] addr;
        logic [7:0]  data;
    } rtcs_bus_s;
endpackage : rtcs_pkg

// File: rtl/rtcs_top.sv
// Clock set, read freeze and oscillator control of a byte-wide timekeeping memory.
//
// Summary of operation
// - Control bit 7 freezes register refresh.
// - Clearing set bit copies registers into counters.
// - Next update within one second after clear.
// - Seconds bit 7 halts the oscillator.
// - Halt accepted whether frozen or running.
// - Halt bit is one from the factory.
// - Oscillator runs within one second of clear.
// - Simultaneous select and write keep outputs off.
// - Bus inputs ignored during recovery delay.
// - Control bit 6 freezes register view.
// - Registers update together; freeze waits for update.
// - Frequency test bit cleared at power up.
`timescale 1ns/1ps
module rtcs_top #(
    parameter int unsigned REC_CYC   = rtcs_pkg::REC_DELAY_CYC,
    parameter int unsigned START_CYC = rtcs_pkg::OSC_START_CYC,
    parameter int unsigned SEC_TICKS = rtcs_pkg::OSC_HZ
) (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        chip_sel_n,
    input  wire logic        write_n,
    input  wire logic        out_en_n,
    input  wire logic [14:0] addr,
    input  wire logic [7:0]  data_in,
    output logic      [7:0]  data_out,
    output logic             data_oe,
    output logic             osc_running,
    output logic             inputs_ready
);
    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers and recovery delay.
    rtcs_pkg::rtcs_bus_s sync1;
    rtcs_pkg::rtcs_bus_s sync2;
    rtcs_pkg::rtcs_bus_s prev;
    logic [31:0]         rec_cnt;
    logic                write_hit;
    logic                read_hit;
    logic                sel_write_fall;

    // Two flops on every pin before any logic sees it.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sync1 <= '{chip_sel_n: 1'b1, write_n: 1'b1, out_en_n: 1'b1, addr: '0, data: '0};
            sync2 <= '{chip_sel_n: 1'b1, write_n: 1'b1, out_en_n: 1'b1, addr: '0, data: '0};
            prev  <= '{chip_sel_n: 1'b1, write_n: 1'b1, out_en_n: 1'b1, addr: '0, data: '0};
        end else begin
            sync1 <= '{chip_sel_n: chip_sel_n, write_n: write_n, out_en_n: out_en_n,
                       addr: addr, data: data_in};
            sync2 <= sync1;
            prev  <= sync2;
        end
    end

    // Reset stands in for the supply rising; the pins are ignored until the count ends.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rec_cnt      <= '0;
            inputs_ready <= 1'b0;
        end else if (!inputs_ready) begin
            rec_cnt <= rec_cnt + 32'd1;
            if (rec_cnt + 32'd1 >= REC_CYC) begin
                inputs_ready <= 1'b1;
            end
        end
    end

    // A write is taken on the rising edge of the write strobe while selected.
    assign write_hit = inputs_ready && !sync2.chip_sel_n && !prev.write_n && sync2.write_n;
    assign read_hit  = inputs_ready && !sync2.chip_sel_n && sync2.write_n && !sync2.out_en_n;
    assign sel_write_fall = prev.chip_sel_n && prev.write_n && !sync2.chip_sel_n && !sync2.write_n;

    ////////////////////////////////////////////////////////////////////////
    // Register cells and counters.
    logic [7:0]  control;
    logic [7:0]  cells [7:1];
    logic [7:0]  counters [7:1];
    logic        set_pending;
    logic        update_req;
    logic [15:0] tick_div;
    logic        osc_tick;
    logic [15:0] sec_cnt;
    logic        sec_pulse;
    logic        frozen;
    logic [31:0] start_cnt;
    logic [2:0]  idx;

    assign frozen = control[rtcs_pkg::SET_TIME_POS] || control[rtcs_pkg::READ_FREEZE_POS];
    assign idx    = addr_index(sync2.addr);

    // Index of a clock byte inside the top eight addresses.
    function automatic logic [2:0] addr_index(input logic [14:0] a);
        return a[2:0];
    endfunction

    // Control byte; clearing the set bit asks for a counter load.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            control     <= rtcs_pkg::BYTE_ZERO;
            set_pending <= 1'b0;
        end else begin
            set_pending <= 1'b0;
            if (write_hit && sync2.addr == rtcs_pkg::ADDR_CONTROL) begin
                control <= sync2.data;
                if (control[rtcs_pkg::SET_TIME_POS] && !sync2.data[rtcs_pkg::SET_TIME_POS]) begin
                    set_pending <= 1'b1;
                end
            end
        end
    end

    // Oscillator divider; halted while the halt bit is set, restarted after a short start-up.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tick_div    <= '0;
            osc_tick    <= 1'b0;
            osc_running <= 1'b0;
            start_cnt   <= '0;
        end else begin
            osc_tick <= 1'b0;
            if (counters[1][rtcs_pkg::OSC_HALT_POS]) begin
                osc_running <= 1'b0;
                start_cnt   <= '0;
                tick_div    <= '0;
            end else if (!osc_running) begin
                start_cnt <= start_cnt + 32'd1;
                if (start_cnt + 32'd1 >= START_CYC) begin
                    osc_running <= 1'b1;
                end
            end else if (tick_div == 16'(rtcs_pkg::OSC_STEP_CYC - 1)) begin
                tick_div <= '0;
                osc_tick <= 1'b1;
            end else begin
                tick_div <= tick_div + 16'd1;
            end
        end
    end

    // Seconds prescaler from oscillator ticks.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sec_cnt   <= '0;
            sec_pulse <= 1'b0;
        end else begin
            sec_pulse <= 1'b0;
            if (osc_tick) begin
                if (sec_cnt == 16'(SEC_TICKS - 1)) begin
                    sec_cnt   <= '0;
                    sec_pulse <= 1'b1;
                end else begin
                    sec_cnt <= sec_cnt + 16'd1;
                end
            end
        end
    end

    // BCD increment with wrap at a limit.
    function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] lim);
        logic [7:0] r;
        r = v;
        if (v >= lim) begin
            r = rtcs_pkg::BYTE_ZERO;
        end else if (v[3:0] == 4'h9) begin
            r = {v[7:4] + 4'h1, 4'h0};
        end else begin
            r = v + 8'h01;
        end
        return r;
    endfunction

    // Only the seconds counter runs, regardless of freeze; a set-bit clear loads all counters from the cells.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 1; i <= 7; i++) begin
                counters[i] <= rtcs_pkg::BYTE_ZERO;
            end
            counters[1] <= rtcs_pkg::SECONDS_RESET;
        end else begin
            if (set_pending) begin
                for (int i = 1; i <= 7; i++) begin
                    counters[i] <= cells[i];
                end
            end else begin
                if (sec_pulse) begin
                    counters[1][6:0] <= 7'(bcd_inc({1'b0, counters[1][6:0]},
                                                    rtcs_pkg::BCD_TEN_SEC_MAX));
                end
                if (write_hit && sync2.addr == rtcs_pkg::ADDR_SECONDS) begin
                    counters[1][rtcs_pkg::OSC_HALT_POS] <= sync2.data[rtcs_pkg::OSC_HALT_POS];
                end
            end
        end
    end

    // Cells follow counters when not frozen and in the cycle after a counter load; host writes go to the cells.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 1; i <= 7; i++) begin
                cells[i] <= rtcs_pkg::BYTE_ZERO;
            end
            cells[1] <= rtcs_pkg::SECONDS_RESET;
            update_req <= 1'b0;
        end else begin
            update_req <= set_pending;
            if (write_hit && sync2.addr >= rtcs_pkg::ADDR_SECONDS) begin
                cells[idx] <= sync2.data;
                if (sync2.addr == rtcs_pkg::ADDR_DAY) begin
                    cells[idx][rtcs_pkg::FREQ_TEST_POS] <= 1'b0;
                end
            end else if (!frozen || update_req) begin
                for (int i = 1; i <= 7; i++) begin
                    cells[i] <= counters[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and output enable.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            data_out <= rtcs_pkg::BYTE_ZERO;
            data_oe  <= 1'b0;
        end else begin
            data_oe <= read_hit && !sel_write_fall;
            if (sync2.addr == rtcs_pkg::ADDR_CONTROL) begin
                data_out <= control;
            end else if (sync2.addr >= rtcs_pkg::ADDR_SECONDS) begin
                data_out <= cells[idx];
            end else begin
                data_out <= rtcs_pkg::BYTE_ZERO;
            end
        end
    end
endmodule : rtcs_top // rtcs_top

// File: dv/rtcs_props.sv
// Checker of bus and oscillator behaviour at the block ports.
`timescale 1ns/1ps
module rtcs_props #(
    parameter int unsigned REC_CYC   = 10,
    parameter int unsigned START_CYC = 5
) (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic        chip_sel_n,
    input wire logic        write_n,
    input wire logic        out_en_n,
    input wire logic [14:0] addr,
    input wire logic [7:0]  data_in,
    input wire logic        data_oe,
    input wire logic        osc_running,
    input wire logic        inputs_ready
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic        wr_q;
    logic        clr_seen;
    logic [31:0] rec_cnt;
    logic [31:0] start_cnt;
    logic        wr_sec;
    // A seconds write lands when the strobe rises with the chip selected.
    assign wr_sec = !chip_sel_n && write_n && !wr_q && inputs_ready && (addr == rtcs_pkg::ADDR_SECONDS);
    // Times the recovery wait and the oscillator start after a clear.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wr_q <= 1'b1;
            clr_seen <= 1'b0;
            rec_cnt <= '0;
            start_cnt <= '0;
        end else begin
            wr_q <= write_n;
            rec_cnt <= inputs_ready ? rec_cnt : rec_cnt + 1;
            if (wr_sec) clr_seen <= !data_in[7];
            if (wr_sec) start_cnt <= {31'h0, !data_in[7]};
            else if (osc_running) start_cnt <= '0;
            else if (start_cnt != 0) start_cnt <= start_cnt + 1;
        end
    end
    ////////////////////////////////////////
    AST_NO_OE_EARLY: assert property (!inputs_ready |-> !data_oe)
        else $error("data driven during recovery");
    AST_READY_HOLD: assert property (inputs_ready |=> inputs_ready)
        else $error("ready dropped");
    AST_READY_TIME: assert property (rec_cnt <= REC_CYC + 4)
        else $error("recovery too long");
    AST_OSC_NEEDS_CLEAR: assert property ($rose(osc_running) |-> clr_seen)
        else $error("oscillator started while halted");
    AST_OSC_START: assert property (start_cnt <= START_CYC + 10)
        else $error("oscillator start late");
    AST_HALT: assert property (wr_sec && data_in[7] |-> ##[1:8] !osc_running)
        else $error("halt not taken");
    AST_NO_OE_CLASH: assert property ($fell(chip_sel_n) && $fell(write_n) |-> ##1 !data_oe [*4])
        else $error("output driven on select with write");
    AST_READ_ANSWER: assert property ((!chip_sel_n && !out_en_n && write_n && inputs_ready) [*4] |-> data_oe)
        else $error("read not answered");
    AST_DESELECT_OFF: assert property (chip_sel_n [*5] |-> !data_oe)
        else $error("output driven while deselected");
    cover property ($rose(osc_running));
    cover property (wr_sec && data_in[7]);
    cover property ($rose(data_oe));
endmodule // rtcs_props
bind rtcs_top rtcs_props #(.REC_CYC(REC_CYC), .START_CYC(START_CYC)) u_props (.clk_sys(clk_sys),
    .reset_n(reset_n), .chip_sel_n(chip_sel_n), .write_n(write_n), .out_en_n(out_en_n), .addr(addr),
    .data_in(data_in), .data_oe(data_oe), .osc_running(osc_running), .inputs_ready(inputs_ready));

// File: dv/rtcs_host.sv
// Host model driving the byte bus of the clock block.
`timescale 1ns/1ps
module rtcs_host (
    input  wire logic           clk_sys,
    output rtcs_pkg::rtcs_bus_s b,
    input  wire logic [7:0]     data_out,
    input  wire logic           data_oe
);
    initial b = '{1'b1, 1'b1, 1'b1, 15'h0000, 8'hFF};
    // Writes one byte with the strobe low for two cycles.
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        b.addr = a;
        b.data = d;
        b.chip_sel_n = 1'b0;
        @(negedge clk_sys);
        b.write_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        b.write_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        b.chip_sel_n = 1'b1;
        b.data = ~d; // Released line shows the inverse.
        repeat (4) @(negedge clk_sys);
    endtask
    // Reads one byte; ok is low when no answer came in time.
    task automatic rd(input logic [14:0] a, output logic [7:0] d, output logic ok);
        int n;
        @(negedge clk_sys);
        b.addr = a;
        b.chip_sel_n = 1'b0;
        b.out_en_n = 1'b0;
        for (n = 0; n < 20 && data_oe !== 1'b1; n++) @(negedge clk_sys);
        @(negedge clk_sys);
        ok = (data_oe === 1'b1);
        d = data_out;
        b.chip_sel_n = 1'b1;
        b.out_en_n = 1'b1;
        repeat (6) @(negedge clk_sys);
    endtask
endmodule // rtcs_host

// File: dv/rtc_set_and_oscillator_control_test.sv
// Testbench of the clock set and oscillator control block.
`timescale 1ns/1ps
module rtc_set_and_oscillator_control_test;
    localparam int SEC_CYC = 4 * rtcs_pkg::OSC_STEP_CYC;
    logic clk_sys, reset_n, data_oe, osc_running, inputs_ready, ok;
    logic [7:0] data_out, d;
    rtcs_pkg::rtcs_bus_s b;
    int failures, checks;
    rtcs_top #(.REC_CYC(10), .START_CYC(5), .SEC_TICKS(4)) u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .chip_sel_n(b.chip_sel_n), .write_n(b.write_n), .out_en_n(b.out_en_n), .addr(b.addr),
        .data_in(b.data), .data_out(data_out), .data_oe(data_oe), .osc_running(osc_running),
        .inputs_ready(inputs_ready));
    rtcs_host u_host (.clk_sys(clk_sys), .b(b), .data_out(data_out), .data_oe(data_oe));
    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Reads a byte and compares the masked value; no answer ends the run.
    task automatic rdc(input logic [14:0] a, input logic [7:0] exp, input logic [7:0] m);
        u_host.rd(a, d, ok);
        chk("answer", 8'h01, {7'h00, ok});
        if (ok !== 1'b1) complete_run();
        chk("read_data", exp, d & m);
    endtask
    task automatic wait_osc(input logic v, input int n);
        for (int i = 0; i < n && osc_running !== v; i++) @(negedge clk_sys);
        chk("osc_running", {7'h00, v}, {7'h00, osc_running});
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////
    initial begin
        failures = 0;
        checks = 0;
        reset_n = 1'b0;
        repeat (20) @(negedge clk_sys);
        reset_n = 1'b1;
        u_host.b.chip_sel_n = 1'b0;
        u_host.b.out_en_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk("data_oe", 8'h00, {7'h00, data_oe});
        u_host.b.chip_sel_n = 1'b1;
        u_host.b.out_en_n = 1'b1;
        repeat (20) @(negedge clk_sys);
        chk("inputs_ready", 8'h01, {7'h00, inputs_ready});
        rdc(rtcs_pkg::ADDR_SECONDS, 8'h80, 8'hFF);
        rdc(rtcs_pkg::ADDR_DAY, 8'h00, 8'h40);
        chk("osc_running", 8'h00, {7'h00, osc_running});
        $display("test power up done");
        u_host.wr(rtcs_pkg::ADDR_SECONDS, 8'h00);
        wait_osc(1'b1, 40);
        u_host.wr(rtcs_pkg::ADDR_CONTROL, 8'h80);
        u_host.wr(rtcs_pkg::ADDR_SECONDS, 8'hA5);
        wait_osc(1'b0, 20);
        u_host.wr(rtcs_pkg::ADDR_SECONDS, 8'h25);
        wait_osc(1'b1, 40);
        repeat (SEC_CYC) @(negedge clk_sys);
        rdc(rtcs_pkg::ADDR_SECONDS, 8'h25, 8'hFF);
        u_host.wr(rtcs_pkg::ADDR_CONTROL, 8'h00);
        rdc(rtcs_pkg::ADDR_SECONDS, 8'h25, 8'hFF);
        repeat (SEC_CYC) @(negedge clk_sys);
        rdc(rtcs_pkg::ADDR_SECONDS, 8'h26, 8'hFF);
        $display("test set time done");
        u_host.wr(rtcs_pkg::ADDR_CONTROL, 8'h40);
        rdc(rtcs_pkg::ADDR_SECONDS, 8'h26, 8'hFF);
        repeat (SEC_CYC) @(negedge clk_sys);
        rdc(rtcs_pkg::ADDR_SECONDS, 8'h26, 8'hFF);
        u_host.wr(rtcs_pkg::ADDR_CONTROL, 8'h00);
        rdc(rtcs_pkg::ADDR_SECONDS, 8'h27, 8'hFF);
        $display("test read freeze done");
        u_host.b.addr = rtcs_pkg::ADDR_CONTROL;
        u_host.b.data = 8'h00;
        u_host.b.out_en_n = 1'b0;
        u_host.b.chip_sel_n = 1'b0;
        u_host.b.write_n = 1'b0;
        repeat (5) @(negedge clk_sys);
        chk("data_oe", 8'h00, {7'h00, data_oe});
        u_host.b.write_n = 1'b1;
        u_host.b.out_en_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        u_host.b.chip_sel_n = 1'b1;
        $display("test select with write done");
        complete_run();
    end
endmodule // rtc_set_and_oscillator_control_test
